/* hw/uss_device.sv */
// Serial transceiver in synchronous slave mode, with its register port and the link end.
//
// Behaviour
// R1: Only the external master makes the shift clock.
// R2: Clearing clock source select selects slave mode.
// R3: Words keep moving while the core sleeps.
// R4: Slave transfers match master transfers except sleep.
// R5: First written word moves straight into shifter.
// R6: Empty flag set only after second word moves; the code sets it whenever holding is empty with transmit enabled, so also once the first word moves.
// R7: Transmit empty with enable raises the wake request.
// R8: Software sets up transmit enables in order.
// R9: Software loads ninth bit before the data.
// R10: Single-receive enable is ignored in slave mode.
// R11: Continuous receive completes words during sleep.
// R12: Finished word enters FIFO and may wake.
// R13: Receive-full flag set on completion; wake if enabled.
// R14: Software sets up receive enables in order.
// R15: Software reads status before the received byte.
// R16: Clearing continuous receive clears the error flags.
// R17: Two-entry FIFO; third word overruns and blocks.
// R18: Ninth bit travels with its byte through FIFO.
// R19: Receive data sampled on falling shift clock.
// R20: Transmit LSB first, changing on rising clock.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module uss_device (
	input wire logic CLK_SYS_I,
	input wire logic ARST_N_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	output logic WAKE_O,
	uss_if.device LINK
);
	logic [7:0] txctl;
	logic [7:0] rxctl;
	logic [7:0] enables;
	logic [7:0] baud;
	logic [7:0] hold;
	logic hold_full;
	logic [8:0] transmit_shift_register;
	logic tsr_full;
	logic tx_armed;
	logic [3:0] tx_cnt;
	logic [8:0] receive_shift_register;
	logic [3:0] rx_cnt;
	logic overrun;
	logic [8:0] fifo [0:1];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] fifo_cnt;
	logic ck_q;
	logic ck_d;
	logic dt_q;

	////////////////////////////////////////////////////////////////////////////////
	// Link inputs come from another clock domain and pass the three-stage synchroniser.
	uss_sync3 u_ck_sync (
		.clk_i(CLK_SYS_I),
		.arst_n_i(ARST_N_I),
		.d_i(LINK.ck),
		.q_o(ck_q)
	);

	uss_sync3 u_dt_sync (
		.clk_i(CLK_SYS_I),
		.arst_n_i(ARST_N_I),
		.d_i(LINK.dt),
		.q_o(dt_q)
	);

	// Edge finder on the filtered clock.
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			ck_d <= 1'b0;
		else
			ck_d <= ck_q;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decode and mode selection. There is no sleep gating anywhere: the serial logic runs
	// from the system clock and the external shift clock, so it works on through sleep.
	wire ck_rise = ck_q & ~ck_d;
	wire ck_fall = ~ck_q & ck_d;
	wire wr_txctl = WR_I && (ADDR_I == uss_pkg::OFS_TXCTL);
	wire wr_rxctl = WR_I && (ADDR_I == uss_pkg::OFS_RXCTL);
	wire wr_enables = WR_I && (ADDR_I == uss_pkg::OFS_ENABLES);
	wire wr_baud = WR_I && (ADDR_I == uss_pkg::OFS_BAUD);
	wire wr_hold = WR_I && (ADDR_I == uss_pkg::OFS_HOLD);
	wire rd_fifo = RD_I && (ADDR_I == uss_pkg::OFS_RXFIFO);
	wire serial_port_enable = rxctl[uss_pkg::RX_SERIAL_PORT_ENABLE];
	wire continuous_receive_enable = rxctl[uss_pkg::RX_CONTINUOUS_RECEIVE_ENABLE];
	wire slave_on = serial_port_enable & txctl[uss_pkg::TX_SYNC_SELECT] & ~txctl[uss_pkg::TX_CLOCK_SOURCE_SELECT]; // R1 R2
	wire tx_on = slave_on & txctl[uss_pkg::TX_TRANSMIT_ENABLE] & ~continuous_receive_enable; // R4
	wire rx_on = slave_on & continuous_receive_enable; // R10 R11
	wire [3:0] tx_bits = txctl[uss_pkg::TX_NINE_BIT_TRANSMIT] ? uss_pkg::BITS_LONG : uss_pkg::BITS_SHORT;
	wire [3:0] rx_bits = rxctl[uss_pkg::RX_NINE_BIT_RECEIVE] ? uss_pkg::BITS_LONG : uss_pkg::BITS_SHORT;
	wire tx_load = tx_on & hold_full & ~tsr_full; // R5 R6
	wire tx_last = tsr_full & ck_fall & (tx_cnt == tx_bits - 4'h1);
	wire [8:0] next_rsr = {dt_q, receive_shift_register[8:1]};
	wire rx_last = rx_on & ~overrun & ck_fall & (rx_cnt == rx_bits - 4'h1); // R19
	wire rx_push = rx_last & (fifo_cnt != 2'h2); // R12 R17
	wire fifo_pop = rd_fifo & (fifo_cnt != 2'h0);
	wire [8:0] rx_word = rxctl[uss_pkg::RX_NINE_BIT_RECEIVE] ? next_rsr : {1'b0, next_rsr[8:1]};
	wire transmit_buffer_empty_flag = txctl[uss_pkg::TX_TRANSMIT_ENABLE] & ~hold_full; // R6
	wire receive_full_flag = fifo_cnt != 2'h0; // R13
	wire receive_ninth_bit = receive_full_flag & fifo[rd_ptr][8]; // R18
	wire [7:0] flags = {2'h0, receive_full_flag, transmit_buffer_empty_flag, 4'h0};
	wire [7:0] rxctl_view = {rxctl[7:3], 1'b0, overrun, receive_ninth_bit};
	wire [7:0] txctl_view = {txctl[7:2], ~tsr_full, txctl[0]};

	////////////////////////////////////////////////////////////////////////////////
	// Software-written control registers. Status fields are overlaid at read time.
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			txctl <= uss_pkg::RST_TXCTL;
			rxctl <= uss_pkg::RST_ZERO;
			enables <= uss_pkg::RST_ZERO;
			baud <= uss_pkg::RST_ZERO;
		end
		else
		begin
			if (wr_txctl)
				txctl <= WDATA_I;
			if (wr_rxctl)
				rxctl <= WDATA_I;
			if (wr_enables)
				enables <= WDATA_I;
			if (wr_baud)
				baud <= WDATA_I;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Holding register. A new write wins over the transfer to the shifter in the same cycle.
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			hold <= uss_pkg::RST_ZERO;
			hold_full <= 1'b0;
		end
		else if (wr_hold)
		begin
			hold <= WDATA_I;
			hold_full <= 1'b1;
		end
		else if (tx_load)
			hold_full <= 1'b0; // R6
	end

	// Transmit shifter. The ninth bit is taken at load time, so it must already be written.
	// The line changes on rising edges only after the first falling edge, keeping bit 0
	// stable for the master's first sample.
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			transmit_shift_register <= 9'h000;
			tsr_full <= 1'b0;
			tx_armed <= 1'b0;
			tx_cnt <= 4'h0;
		end
		else if (tx_load)
		begin
			transmit_shift_register <= {txctl[uss_pkg::TX_TRANSMIT_NINTH_BIT], hold}; // R5 R9
			tsr_full <= 1'b1;
			tx_armed <= 1'b0;
			tx_cnt <= 4'h0;
		end
		else if (!tx_on)
			tsr_full <= 1'b0;
		else if (tsr_full && ck_rise && tx_armed)
			transmit_shift_register <= {1'b0, transmit_shift_register[8:1]}; // R20
		else if (tsr_full && ck_fall)
		begin
			tx_armed <= 1'b1;
			tx_cnt <= tx_cnt + 4'h1;
			if (tx_last)
				tsr_full <= 1'b0; // R6
		end
	end

	// The device drives the data line only while a word is in the shifter.
	assign LINK.dev_dt_o = transmit_shift_register[0]; // R20
	assign LINK.dev_dt_oe = tsr_full & tx_on; // R1

	////////////////////////////////////////////////////////////////////////////////
	// Receive shifter. Clearing continuous receive drops a partial word and the error flags.
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			receive_shift_register <= 9'h000;
			rx_cnt <= 4'h0;
			overrun <= 1'b0;
		end
		else if (!rx_on)
		begin
			rx_cnt <= 4'h0;
			overrun <= 1'b0; // R16
		end
		else if (ck_fall && !overrun)
		begin
			receive_shift_register <= next_rsr; // R19
			if (rx_last)
			begin
				rx_cnt <= 4'h0;
				overrun <= ~rx_push; // R17
			end
			else
				rx_cnt <= rx_cnt + 4'h1;
		end
	end

	// Two-entry receive FIFO holding nine bits per entry.
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			fifo[0] <= 9'h000;
			fifo[1] <= 9'h000;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			fifo_cnt <= 2'h0;
		end
		else
		begin
			if (rx_push)
			begin
				fifo[wr_ptr] <= rx_word; // R12 R18
				wr_ptr <= ~wr_ptr;
			end
			if (fifo_pop)
				rd_ptr <= ~rd_ptr; // R18
			fifo_cnt <= fifo_cnt + {1'b0, rx_push} - {1'b0, fifo_pop};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data stand in the cycle after the strobe; unmapped addresses read zero.
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			RDATA_O <= uss_pkg::RST_ZERO;
		else if (!RD_I)
			RDATA_O <= uss_pkg::RST_ZERO;
		else
		begin
			unique case (ADDR_I)
				uss_pkg::OFS_FLAGS: RDATA_O <= flags;
				uss_pkg::OFS_RXCTL: RDATA_O <= rxctl_view; // R15
				uss_pkg::OFS_RXFIFO: RDATA_O <= fifo[rd_ptr][7:0];
				uss_pkg::OFS_ENABLES: RDATA_O <= enables;
				uss_pkg::OFS_TXCTL: RDATA_O <= txctl_view;
				uss_pkg::OFS_BAUD: RDATA_O <= baud;
				default: RDATA_O <= uss_pkg::RST_ZERO;
			endcase
		end
	end

	// Wake request to the core: a flag gated by its enable.
	assign WAKE_O = (transmit_buffer_empty_flag & enables[uss_pkg::IRQ_TRANSMIT]) | (receive_full_flag & enables[uss_pkg::IRQ_RECEIVE]); // R7 R12 R13 R3
endmodule

/* inc/uss_pkg.sv */
// Constants shared by both ends of the synchronous slave serial link.
package uss_pkg;
	// Register offsets on the device's register port.
	localparam logic [7:0] OFS_FLAGS = 8'h0c;
	localparam logic [7:0] OFS_RXCTL = 8'h18;
	localparam logic [7:0] OFS_HOLD = 8'h19;
	localparam logic [7:0] OFS_RXFIFO = 8'h1a;
	localparam logic [7:0] OFS_ENABLES = 8'h8c;
	localparam logic [7:0] OFS_TXCTL = 8'h98;
	localparam logic [7:0] OFS_BAUD = 8'h99;
	// Field positions in transmit_status_control.
	localparam int TX_CLOCK_SOURCE_SELECT = 7;
	localparam int TX_NINE_BIT_TRANSMIT = 6;
	localparam int TX_TRANSMIT_ENABLE = 5;
	localparam int TX_SYNC_SELECT = 4;
	localparam int TX_HIGH_BAUD = 2;
	localparam int TX_SHIFT_REGISTER_EMPTY = 1;
	localparam int TX_TRANSMIT_NINTH_BIT = 0;
	// Field positions in receive_status_control.
	localparam int RX_SERIAL_PORT_ENABLE = 7;
	localparam int RX_NINE_BIT_RECEIVE = 6;
	localparam int RX_SINGLE_RECEIVE_ENABLE = 5;
	localparam int RX_CONTINUOUS_RECEIVE_ENABLE = 4;
	localparam int RX_ADDRESS_DETECT_ENABLE = 3;
	localparam int RX_FRAMING_ERROR = 2;
	localparam int RX_OVERRUN_ERROR = 1;
	localparam int RX_RECEIVE_NINTH_BIT = 0;
	// Field positions in the interrupt flag and enable registers.
	localparam int IRQ_RECEIVE = 5;
	localparam int IRQ_TRANSMIT = 4;
	// Reset values.
	localparam logic [7:0] RST_TXCTL = 8'h02;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// Word lengths in bits.
	localparam logic [3:0] BITS_SHORT = 4'h8;
	localparam logic [3:0] BITS_LONG = 4'h9;
	// Shift clock made by the master end.
	localparam int SYS_PERIOD_NS = 10;
	localparam int SHIFT_PERIOD_NS = 160;
	localparam logic [3:0] HALF_CYCLES = 4'(SHIFT_PERIOD_NS / (2 * SYS_PERIOD_NS));
	// Master end states.
	typedef enum logic [2:0]
	{
		MST_IDLE = 3'b001,
		MST_RUN = 3'b010,
		MST_DONE = 3'b100
	} uss_mst_state_e;
endpackage

/* inc/uss_if.sv */
// Link between the slave device and the external master: shift clock and shared data line.
`timescale 1ns/1ps
interface uss_if;
	logic ck;
	logic dev_dt_o;
	logic dev_dt_oe;
	logic mst_dt_o;
	logic mst_dt_oe;
	logic dt;

	// The data line idles high through a pull-up when nobody drives it.
	assign dt = dev_dt_oe ? dev_dt_o : (mst_dt_oe ? mst_dt_o : 1'b1);

	modport device (input ck, input dt, output dev_dt_o, output dev_dt_oe);
	modport master (output ck, input dt, output mst_dt_o, output mst_dt_oe);
endinterface

/* hw/uss_sync3.sv */
// Three-stage pin synchroniser whose output follows once stages two and three agree.
`timescale 1ns/1ps
module uss_sync3 (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic d_i,
	output logic q_o
);
	logic s1;
	logic s2;
	logic s3;

	// The first stage feeds only the second, so a metastable level never reaches a gate.
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			q_o <= 1'b0;
		end
		else
		begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				q_o <= s3;
		end
	end
endmodule

/* hw/uss_master.sv */
// External synchronous master: makes the shift clock and sends or receives one word per order.
`timescale 1ns/1ps
module uss_master (
	input wire logic CLK_SYS_I,
	input wire logic ARST_N_I,
	input wire logic GO_I,
	input wire logic SEND_I,
	input wire logic NINE_I,
	input wire logic [8:0] DATA_I,
	output logic BUSY_O,
	output logic DONE_O,
	output logic [8:0] DATA_O,
	uss_if.master LINK
);
	uss_pkg::uss_mst_state_e state;
	logic [3:0] div;
	logic [3:0] bit_cnt;
	logic [8:0] sh;
	logic send;
	logic nine;
	logic ck;
	logic dt_out;
	logic dt_q;

	// The data line returning from the device is a pin from outside this clock's edges.
	uss_sync3 u_dt_sync (
		.clk_i(CLK_SYS_I),
		.arst_n_i(ARST_N_I),
		.d_i(LINK.dt),
		.q_o(dt_q)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Divider and bit sequencing; the clock idles low and runs only during a word.
	// Returning data passes a synchroniser at both ends, so it is taken in the middle of each low
	// phase: at the falling edge itself the device's new bit would not yet be visible here.
	wire half = (div == uss_pkg::HALF_CYCLES - 4'h1);
	wire mid_low = (div == (uss_pkg::HALF_CYCLES >> 1) - 4'h1);
	wire [3:0] word_bits = nine ? uss_pkg::BITS_LONG : uss_pkg::BITS_SHORT;
	wire going_low = (state == uss_pkg::MST_RUN) && half && ck;
	wire going_high = (state == uss_pkg::MST_RUN) && half && !ck;
	wire take = (state == uss_pkg::MST_RUN) && !ck && mid_low && (bit_cnt != 4'h0);
	wire [8:0] next_sh = {dt_q, sh[8:1]};

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			state <= uss_pkg::MST_IDLE;
			div <= 4'h0;
			bit_cnt <= 4'h0;
			ck <= 1'b0;
		end
		else
		begin
			unique case (state)
				uss_pkg::MST_IDLE:
					if (GO_I)
					begin
						state <= uss_pkg::MST_RUN;
						div <= 4'h0;
						bit_cnt <= 4'h0;
					end
				uss_pkg::MST_RUN:
				begin
					div <= half ? 4'h0 : div + 4'h1;
					if (half)
						ck <= ~ck; // R1
					if (going_low)
						bit_cnt <= bit_cnt + 4'h1;
					if (take && (bit_cnt == word_bits))
						state <= uss_pkg::MST_DONE;
				end
				uss_pkg::MST_DONE:
					state <= uss_pkg::MST_IDLE;
			endcase
		end
	end

	// Shift register: data out changes on the rising edge, data in is taken mid low phase.
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			sh <= 9'h000;
			send <= 1'b0;
			nine <= 1'b0;
			dt_out <= 1'b1;
		end
		else if (state == uss_pkg::MST_IDLE && GO_I)
		begin
			sh <= DATA_I;
			send <= SEND_I;
			nine <= NINE_I;
		end
		else if (going_high)
			dt_out <= sh[0];
		else if (take)
			sh <= next_sh; // R19
	end

	// Results are captured from the shifter when the word ends.
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			DATA_O <= 9'h000;
		else if (state == uss_pkg::MST_DONE)
			DATA_O <= nine ? sh : {1'b0, sh[8:1]};
	end

	assign LINK.ck = ck;
	assign LINK.mst_dt_o = dt_out;
	assign LINK.mst_dt_oe = send && (state == uss_pkg::MST_RUN);
	assign BUSY_O = (state != uss_pkg::MST_IDLE);
	assign DONE_O = (state == uss_pkg::MST_DONE);
endmodule

/* test/uss_asserts.sv */
// Concurrent checks on the link between the slave device and the external master.
`timescale 1ns/1ps
module uss_asserts (
	input wire logic CLK_SYS_I,
	input wire logic ARST_N_I,
	input wire logic ck,
	input wire logic dev_dt_o,
	input wire logic dev_dt_oe,
	input wire logic mst_dt_o,
	input wire logic mst_dt_oe,
	input wire logic dt
);
	logic ck_q;
	logic [3:0] tx_falls;

	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!ARST_N_I);

	////////////////////////////////////////////////////////////////////////
	// Counts shift clock falls while the device drives, so a word's length is visible.
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			ck_q <= 1'b0;
			tx_falls <= 4'h0;
		end
		else
		begin
			ck_q <= ck;
			tx_falls <= !dev_dt_oe ? 4'h0 : tx_falls + 4'(ck_q && !ck);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// The high phase of the shift clock lasts exactly eight system cycles.
	sequence s_ck_high;
		ck [*8];
	endsequence

	a_one_driver: assert property (!(dev_dt_oe && mst_dt_oe))
		else $error("both ends drive the data line");
	a_ck_half_period: assert property ($rose(ck) |-> s_ck_high ##1 !ck)
		else $error("shift clock high phase has the wrong length");
	a_tx_bit_held: assert property ($fell(ck) && dev_dt_oe |-> dev_dt_o == $past(dev_dt_o, 3))
		else $error("device data moved just before the sampling edge");
	a_mst_bit_held: assert property ($fell(ck) && mst_dt_oe |-> mst_dt_o == $past(mst_dt_o, 3))
		else $error("master data moved just before the sampling edge");
	a_tx_word_len: assert property ($fell(dev_dt_oe) |-> tx_falls == 4'h8 || tx_falls == 4'h9)
		else $error("device released the line after a wrong bit count");
	a_tx_starts_low: assert property ($rose(dev_dt_oe) |-> !ck)
		else $error("device started a word while the clock was high");
	a_tx_change_window: assert property (dev_dt_oe && $past(dev_dt_oe) && $changed(dev_dt_o) |-> ck)
		else $error("device changed its bit outside the clock high phase");
	a_line_pullup: assert property (!dev_dt_oe && !mst_dt_oe |-> dt)
		else $error("released data line is not high");
endmodule

/* test/uss_tb.sv */
// Self-checking bench joining the slave device and the external master over the link.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module uss_tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic go = 1'b0;
	logic send = 1'b0;
	logic nine = 1'b0;
	logic [8:0] mdata = 9'h000;
	logic [7:0] rdata;
	logic wake;
	logic done;
	logic busy;
	logic [8:0] mrx;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;

	uss_if link();
	uss_device u_uss_device (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdata), .WAKE_O(wake), .LINK(link));
	uss_master u_uss_master (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .GO_I(go), .SEND_I(send), .NINE_I(nine),
		.DATA_I(mdata), .BUSY_O(busy), .DONE_O(done), .DATA_O(mrx), .LINK(link));
	uss_asserts u_uss_asserts (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .ck(link.ck), .dev_dt_o(link.dev_dt_o),
		.dev_dt_oe(link.dev_dt_oe), .mst_dt_o(link.mst_dt_o), .mst_dt_oe(link.mst_dt_oe), .dt(link.dt));

	// System clock; the master divides it down for the shift clock.
	always #5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	// Register port cycles: a read's data is only valid in the cycle after the strobe.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(nm, e, rdata)
	endtask

	// One master word; the trailing wait lets the device see the last synced edge.
	task automatic xfer(input logic snd, input logic nn, input logic [8:0] d, input logic [8:0] e);
		int i;
		i = 0;
		@(posedge clk);
		go <= 1'b1;
		send <= snd;
		nine <= nn;
		mdata <= d;
		@(posedge clk);
		go <= 1'b0;
		#1;
		`CHK("master busy", 1'b1, busy)
		while (done !== 1'b1 && i < 400)
		begin
			@(posedge clk);
			#1;
			i++;
		end
		// A word that never finishes is counted here as a mismatch.
		`CHK("master done", 1'b1, done)
		@(posedge clk);
		#1;
		if (!snd)
			`CHK("master word", e, mrx)
		`CHK("master idle", 1'b0, busy)
		repeat (8) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset_values();
		logic [7:0] ofs [6];
		ofs = '{uss_pkg::OFS_FLAGS, uss_pkg::OFS_RXCTL, uss_pkg::OFS_HOLD, uss_pkg::OFS_ENABLES, uss_pkg::OFS_BAUD, 8'h55};
		foreach (ofs[k])
			rd_chk(ofs[k], uss_pkg::RST_ZERO, "reset value");
		rd_chk(uss_pkg::OFS_TXCTL, uss_pkg::RST_TXCTL, "txctl reset");
		wr_reg(uss_pkg::OFS_BAUD, 8'ha7);
		wr_reg(uss_pkg::OFS_FLAGS, 8'hff);
		rd_chk(uss_pkg::OFS_BAUD, 8'ha7, "baud");
		rd_chk(uss_pkg::OFS_FLAGS, 8'h00, "flags read only");
	endtask

	// Two queued words: the second waits in holding and the empty flag stays low meanwhile.
	task automatic t_tx_two_words();
		wr_reg(uss_pkg::OFS_RXCTL, 8'h80);
		wr_reg(uss_pkg::OFS_ENABLES, 8'h10);
		wr_reg(uss_pkg::OFS_TXCTL, 8'h30);
		rd_chk(uss_pkg::OFS_FLAGS, 8'h10, "flags idle");
		wr_reg(uss_pkg::OFS_HOLD, 8'ha5);
		wr_reg(uss_pkg::OFS_HOLD, 8'h3c);
		rd_chk(uss_pkg::OFS_FLAGS, 8'h00, "flags queued");
		`CHK("wake queued", 1'b0, wake)
		rd_chk(uss_pkg::OFS_TXCTL, 8'h30, "shifter busy");
		xfer(1'b0, 1'b0, 9'h000, 9'h0a5);
		rd_chk(uss_pkg::OFS_FLAGS, 8'h10, "flags moved");
		`CHK("wake moved", 1'b1, wake)
		xfer(1'b0, 1'b0, 9'h000, 9'h03c);
		rd_chk(uss_pkg::OFS_TXCTL, 8'h32, "shifter empty");
	endtask

	// The ninth bit is loaded before the byte that starts the word.
	task automatic t_tx_nine();
		wr_reg(uss_pkg::OFS_TXCTL, 8'h71);
		wr_reg(uss_pkg::OFS_HOLD, 8'h5a);
		xfer(1'b0, 1'b1, 9'h000, 9'h15a);
		wr_reg(uss_pkg::OFS_TXCTL, 8'h10);
	endtask

	// Reception: single receive ignored, FIFO of two, overrun blocks until cleared.
	task automatic t_rx();
		wr_reg(uss_pkg::OFS_RXCTL, 8'ha0);
		xfer(1'b1, 1'b0, 9'h066, 9'h000);
		rd_chk(uss_pkg::OFS_FLAGS, 8'h00, "single ignored");
		wr_reg(uss_pkg::OFS_ENABLES, 8'h20);
		wr_reg(uss_pkg::OFS_RXCTL, 8'hd0);
		xfer(1'b1, 1'b1, 9'h133, 9'h000);
		rd_chk(uss_pkg::OFS_FLAGS, 8'h20, "receive full");
		`CHK("wake rx", 1'b1, wake)
		xfer(1'b1, 1'b1, 9'h0c4, 9'h000);
		xfer(1'b1, 1'b1, 9'h177, 9'h000);
		rd_chk(uss_pkg::OFS_RXCTL, 8'hd3, "overrun head");
		rd_chk(uss_pkg::OFS_RXFIFO, 8'h33, "fifo first");
		rd_chk(uss_pkg::OFS_RXCTL, 8'hd2, "ninth next");
		rd_chk(uss_pkg::OFS_RXFIFO, 8'hc4, "fifo second");
		xfer(1'b1, 1'b1, 9'h1ee, 9'h000);
		rd_chk(uss_pkg::OFS_FLAGS, 8'h00, "blocked");
		wr_reg(uss_pkg::OFS_RXCTL, 8'h80);
		rd_chk(uss_pkg::OFS_RXCTL, 8'h80, "errors cleared");
		wr_reg(uss_pkg::OFS_RXCTL, 8'h90);
		wr_reg(uss_pkg::OFS_ENABLES, 8'h00);
		xfer(1'b1, 1'b0, 9'h05b, 9'h000);
		rd_chk(uss_pkg::OFS_FLAGS, 8'h20, "received again");
		`CHK("wake masked", 1'b0, wake)
		rd_chk(uss_pkg::OFS_RXFIFO, 8'h5b, "fifo byte");
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("mismatches %0d of %0d comparisons", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// A hung handshake must not stall the run; the ceiling is far above the expected length.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end

	// Main sequence.
	initial
	begin
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		t_reset_values();
		t_tx_two_words();
		t_tx_nine();
		t_rx();
		tally_and_finish();
	end
endmodule
